// [src/hpalk_pkg.sv]
// Package for the protected-area lock and unlock command handler
package hpalk_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_SUBCMD = 8'h00;
    localparam logic [7:0] OFF_DRVHEAD = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_ERROR = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_DATA = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_INFO = 8'h1C;
    localparam logic [7:0] OFF_PWBASE = 8'h40;
    localparam logic [7:0] OFF_PWEND = 8'h7C;
    // Command and subcommand codes
    localparam logic [7:0] CMD_SETMAX = 8'hF9;
    localparam logic [7:0] CMD_READNATIVE = 8'hF8;
    localparam logic [7:0] SUB_SETPW = 8'h01;
    localparam logic [7:0] SUB_LOCK = 8'h02;
    localparam logic [7:0] SUB_UNLOCK = 8'h03;
    localparam logic [7:0] SUB_FREEZE = 8'h04;
    // Status, error and drive/head bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_IDNF = 4;
    localparam int ER_ABRT = 2;
    localparam int DH_DEV = 4;
    // Sector layout in 16-bit words
    localparam logic [7:0] PW_FIRST = 8'h01;
    localparam logic [7:0] PW_LAST = 8'h10;
    localparam logic [7:0] SECT_LAST = 8'hFF;
    // Reset values and AXI response codes
    localparam logic [7:0] STATUS_RST = 8'h40;
    localparam logic [2:0] UNLOCK_TRIES = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {HPALK_UNLOCKED, HPALK_LOCKED, HPALK_FROZEN} hpalk_lock_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } hpalk_wreq_t;
endpackage : hpalk_pkg

// [src/hpalk_core.sv]
// Lock and unlock command handler of the protected-area feature, AXI4-Lite slave
// Overview of operation
// - Unlock is command F9h with subcommand register 03h.
// - Lock is command F9h with subcommand register 02h.
// - Lock has no data phase and completes without raising DRQ.
// - Unlock takes exactly one 256-word sector from the host.
// - Success clears BSY, DF, DRQ, ERR and sets DRDY.
// - Error completion clears BSY, sets DRDY, sets ERR if any error bit.
// - ABRT is bit 2, set when unsupported or not locked; IDNF is bit 4.
// - ABRT may flag an action the device cannot carry out.
// - DEV bit 4 of the drive/head register keeps showing the selected device.
// - Directly after a native max read, these act as set max address.
// - Accepted lock enters the locked state.
// - While locked, every set max subcommand but unlock and freeze is refused.
// - Locked holds until power cycle, accepted unlock or freeze.
// - Password is held until power cycle; set password leaves device unlocked.
// - Unlock compares the received password with the stored one.
// - Mismatch aborts the unlock and decrements the attempt counter.
// - Lock loads the counter with five; mismatch while locked decrements it.
// - At zero attempts every unlock is aborted until power cycle.
// - Match enters the unlocked state, where lock, set password and freeze are accepted again; unlock is refused.
`timescale 1ns/10ps
`default_nettype none
module hpalk_core #(
    parameter int CNT_W = 3
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output hpalk_pkg::hpalk_lock_t lockState,
    output logic setMaxAddrReq
);
    import hpalk_pkg::*;

    if (CNT_W < 3) begin : g_chk
        $error("CNT_W must be at least 3");
    end

    typedef enum {CS_IDLE, CS_DATA, CS_DONE} hpalk_cmd_t;

    hpalk_cmd_t cmdState_q;
    hpalk_wreq_t wreq_q;
    logic awHave_q, wHave_q;
    logic [7:0] subcmd_q, drvHead_q, error_q, status_q;
    logic [7:0] wordIdx_q;
    logic [CNT_W-1:0] tries_q;
    logic [15:0] storedPw_q [0:15];
    logic pwValid_q, mismatch_q, prevNative_q;
    logic isSetPw_q;
    logic [CNT_W-1:0] triesInit;

    function automatic logic [7:0] regByte(input logic [31:0] d);
        return d[7:0];
    endfunction : regByte

    assign triesInit = CNT_W'(UNLOCK_TRIES);

    // Write channel capture; address and data taken in either order
    wire wrFire = awHave_q && wHave_q && !s_axi_bvalid;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            wreq_q <= '0;
        end else begin
            s_axi_awready <= !awHave_q && !s_axi_awready;
            s_axi_wready <= !wHave_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                wreq_q.awaddr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wreq_q.wdata <= s_axi_wdata;
                wreq_q.wstrb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
            end
        end
    end

    wire wrLow = wreq_q.wstrb[0];
    wire wrSub = wrFire && wrLow && wreq_q.awaddr == OFF_SUBCMD;
    wire wrDh = wrFire && wrLow && wreq_q.awaddr == OFF_DRVHEAD;
    wire wrCmd = wrFire && wrLow && wreq_q.awaddr == OFF_CMD && !status_q[ST_BSY];
    wire wrData = wrFire && wreq_q.awaddr == OFF_DATA && cmdState_q == CS_DATA;
    wire wrPw = wrFire && wreq_q.awaddr >= OFF_PWBASE && wreq_q.awaddr <= OFF_PWEND;
    wire wrMapped = wreq_q.awaddr == OFF_SUBCMD || wreq_q.awaddr == OFF_DRVHEAD
        || wreq_q.awaddr == OFF_CMD || wreq_q.awaddr == OFF_DATA
        || (wreq_q.awaddr >= OFF_PWBASE && wreq_q.awaddr <= OFF_PWEND);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            subcmd_q <= 8'h00;
        end else if (wrSub) begin
            subcmd_q <= regByte(wreq_q.wdata);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drvHead_q <= 8'h00;
        end else if (wrDh) begin
            drvHead_q <= regByte(wreq_q.wdata);
        end
    end

    // Register-window write of the stored password (set password data path)
    // Password kept until power cycle
    always_ff @(posedge core_clk) begin
        if (wrPw) begin
            storedPw_q[4'(wreq_q.awaddr[5:2])] <= wreq_q.wdata[15:0];
        end
    end

    wire isF9 = regByte(wreq_q.wdata) == CMD_SETMAX;
    wire isLock = isF9 && subcmd_q == SUB_LOCK;
    wire isUnlock = isF9 && subcmd_q == SUB_UNLOCK;
    wire isSetPw = isF9 && subcmd_q == SUB_SETPW;
    wire isFreeze = isF9 && subcmd_q == SUB_FREEZE;
    wire inPw = wordIdx_q >= PW_FIRST && wordIdx_q <= PW_LAST;
    wire [3:0] pwIdx = 4'(wordIdx_q - PW_FIRST);

    // Command state, lock state, attempt counter, status and error
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmdState_q <= CS_IDLE;
            lockState <= HPALK_UNLOCKED;
            tries_q <= CNT_W'(UNLOCK_TRIES);
            status_q <= STATUS_RST;
            error_q <= 8'h00;
            wordIdx_q <= 8'h00;
            mismatch_q <= 1'b0;
            pwValid_q <= 1'b0;
            prevNative_q <= 1'b0;
            setMaxAddrReq <= 1'b0;
            isSetPw_q <= 1'b0;
        end else begin
            setMaxAddrReq <= 1'b0;
            unique case (cmdState_q)
                CS_IDLE: begin
                    if (wrCmd) begin
                        prevNative_q <= regByte(wreq_q.wdata) == CMD_READNATIVE;
                        error_q <= 8'h00;
                        // Right after native max read, hand off as set max address
                        if (isF9 && prevNative_q) begin
                            setMaxAddrReq <= 1'b1;
                            status_q <= STATUS_RST;
                        // Locked refuses all but unlock and freeze
                        end else if ((isLock || isSetPw) && lockState != HPALK_UNLOCKED) begin
                            error_q[ER_ABRT] <= 1'b1;
                            status_q <= 8'h41;
                        end else if (isLock) begin
                            lockState <= HPALK_LOCKED;
                            tries_q <= triesInit;
                            status_q <= 8'h40;
                        // Unlock while not locked or out of tries is aborted
                        end else if (isUnlock && (lockState != HPALK_LOCKED || tries_q == '0)) begin
                            error_q[ER_ABRT] <= 1'b1;
                            status_q <= 8'h41;
                        // Unlock and set password open one-sector data phase
                        end else if (isUnlock || isSetPw) begin
                            cmdState_q <= CS_DATA;
                            isSetPw_q <= isSetPw;
                            wordIdx_q <= 8'h00;
                            mismatch_q <= 1'b0;
                            status_q <= 8'h48;
                        end else if (isFreeze) begin
                            // Freeze ends locked only once a password exists
                            if (lockState == HPALK_FROZEN || !pwValid_q) begin
                                error_q[ER_ABRT] <= 1'b1;
                                status_q <= 8'h41;
                            end else begin
                                lockState <= HPALK_FROZEN;
                                status_q <= 8'h40;
                            end
                        end else begin
                            // Anything else here is not supported
                            error_q[ER_ABRT] <= 1'b1;
                            status_q <= 8'h41;
                        end
                    end
                end
                CS_DATA: begin
                    if (wrData) begin
                        wordIdx_q <= wordIdx_q + 8'h01;
                        // Only words 1 to 16 matter
                        if (inPw && !isSetPw_q && wreq_q.wdata[15:0] != storedPw_q[pwIdx]) begin
                            mismatch_q <= 1'b1;
                        end
                        if (wordIdx_q == SECT_LAST) begin
                            cmdState_q <= CS_DONE;
                            status_q <= 8'h80;
                        end
                    end
                end
                CS_DONE: begin
                    cmdState_q <= CS_IDLE;
                    if (isSetPw_q) begin
                        pwValid_q <= 1'b1;
                        lockState <= HPALK_UNLOCKED;
                        status_q <= 8'h40;
                    end else if (mismatch_q) begin
                        // Mismatch aborts and uses up a try
                        error_q[ER_ABRT] <= 1'b1;
                        status_q <= 8'h41;
                        if (tries_q != '0) begin
                            tries_q <= tries_q - CNT_W'(1);
                        end
                    end else begin
                        lockState <= HPALK_UNLOCKED;
                        status_q <= 8'h40;
                    end
                end
            endcase
        end
    end

    // Read channel
    logic [31:0] rdMux;
    logic rdOk;
    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        unique case (s_axi_araddr)
            OFF_SUBCMD: rdMux = {24'h000000, subcmd_q};
            OFF_DRVHEAD: rdMux = {24'h000000, drvHead_q};
            OFF_CMD: rdMux = 32'h0000_0000;
            OFF_ERROR: rdMux = {24'h000000, error_q};
            OFF_STATUS: rdMux = {24'h000000, status_q};
            OFF_CTRL: rdMux = {24'h000000, 7'h00, drvHead_q[DH_DEV]};
            OFF_INFO: rdMux = {16'h0000, 8'(tries_q), 6'h00, 2'(lockState)};
            default: rdOk = s_axi_araddr >= OFF_PWBASE && s_axi_araddr <= OFF_PWEND;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    property p_lock_loads;
        @(posedge core_clk) disable iff (!rstn)
        (wrCmd && cmdState_q == CS_IDLE && isLock && !prevNative_q && lockState == HPALK_UNLOCKED)
        |=> lockState == HPALK_LOCKED && tries_q == triesInit && status_q == 8'h40;
    endproperty
    a_lock_loads: assert property (p_lock_loads) else $error("lock did not load");

    property p_abrt_err;
        @(posedge core_clk) disable iff (!rstn)
        error_q[ER_ABRT] |-> status_q[ST_ERR] && status_q[ST_DRDY] && !status_q[ST_BSY];
    endproperty
    a_abrt_err: assert property (p_abrt_err) else $error("ABRT without ERR");

    property p_ok_clean;
        @(posedge core_clk) disable iff (!rstn)
        (cmdState_q == CS_IDLE && error_q == 8'h00) |-> status_q == 8'h40;
    endproperty
    a_ok_clean: assert property (p_ok_clean) else $error("bad success status");

    property p_no_underflow;
        @(posedge core_clk) disable iff (!rstn)
        tries_q == '0 |=> tries_q == '0;
    endproperty
    a_no_underflow: assert property (p_no_underflow) else $error("counter wrapped");

    property p_mismatch_dec;
        @(posedge core_clk) disable iff (!rstn)
        (cmdState_q == CS_DONE && !isSetPw_q && mismatch_q && tries_q != '0)
        |=> tries_q == $past(tries_q) - CNT_W'(1) && error_q[ER_ABRT];
    endproperty
    a_mismatch_dec: assert property (p_mismatch_dec) else $error("mismatch not counted");

    property p_match_unlock;
        @(posedge core_clk) disable iff (!rstn)
        (cmdState_q == CS_DONE && !isSetPw_q && !mismatch_q) |=> lockState == HPALK_UNLOCKED;
    endproperty
    a_match_unlock: assert property (p_match_unlock) else $error("match did not unlock");

    property p_zero_abort;
        @(posedge core_clk) disable iff (!rstn)
        (wrCmd && cmdState_q == CS_IDLE && isUnlock && !prevNative_q && tries_q == '0)
        |=> error_q[ER_ABRT] && cmdState_q == CS_IDLE;
    endproperty
    a_zero_abort: assert property (p_zero_abort) else $error("unlock at zero ran");

    property p_lock_nodrq;
        @(posedge core_clk) disable iff (!rstn)
        (wrCmd && cmdState_q == CS_IDLE && isLock) |=> !status_q[ST_DRQ];
    endproperty
    a_lock_nodrq: assert property (p_lock_nodrq) else $error("lock raised DRQ");

    property p_locked_refuse;
        @(posedge core_clk) disable iff (!rstn)
        (wrCmd && cmdState_q == CS_IDLE && isSetPw && !prevNative_q && lockState == HPALK_LOCKED)
        |=> error_q[ER_ABRT];
    endproperty
    a_locked_refuse: assert property (p_locked_refuse) else $error("locked accepted");

    property p_native_handoff;
        @(posedge core_clk) disable iff (!rstn)
        (wrCmd && cmdState_q == CS_IDLE && isF9 && prevNative_q)
        |=> setMaxAddrReq && $stable(lockState);
    endproperty
    a_native_handoff: assert property (p_native_handoff) else $error("no handoff");

    // Sector end: busy for one cycle, then a completion without DRQ
    sequence s_last_word;
        cmdState_q == CS_DATA && wrData && wordIdx_q == SECT_LAST;
    endsequence
    sequence s_busy_then_done;
        status_q == 8'h80 ##1 (!status_q[ST_BSY] && status_q[ST_DRDY] && !status_q[ST_DRQ]);
    endsequence
    property p_sector_end;
        @(posedge core_clk) disable iff (!rstn)
        s_last_word |=> s_busy_then_done;
    endproperty
    a_sector_end: assert property (p_sector_end) else $error("sector end not completed");

    property p_unlock_drq;
        @(posedge core_clk) disable iff (!rstn)
        (wrCmd && cmdState_q == CS_IDLE && isUnlock && !prevNative_q && lockState == HPALK_LOCKED
            && tries_q != '0) |=> cmdState_q == CS_DATA && status_q == 8'h48;
    endproperty
    a_unlock_drq: assert property (p_unlock_drq) else $error("unlock did not open data");
endmodule : hpalk_core
`default_nettype wire

// [bench/hpalk_host.sv]
// Host controller model: AXI4-Lite master that issues register cycles
`timescale 1ns/10ps
`default_nettype none
module hpalk_host (
    input wire logic core_clk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aOk;
        logic wOk;
        aOk = 1'b0;
        wOk = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aOk && wOk)) begin
            @(posedge core_clk);
            // Released payload is scrambled so stale values cannot pass
            if (awready && !aOk) begin
                aOk = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wready && !wOk) begin
                wOk = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        while (!bvalid) begin
            @(posedge core_clk);
        end
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        while (!rvalid) begin
            @(posedge core_clk);
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : hpalk_host
`default_nettype wire

// [bench/test_hpalk_core.sv]
// Self-checking bench for the protected-area lock and unlock handler
`timescale 1ns/10ps
`default_nettype none
module test_hpalk_core;
    import hpalk_pkg::*;
    typedef struct packed {logic [7:0] sub; logic [7:0] st; logic [7:0] er; logic [1:0] lk;} hpalk_row_t;
    logic core_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, setMaxAddrReq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    hpalk_lock_t lockState;
    int nMismatch = 0;
    int comparisons = 0;
    int nPulse = 0;
    hpalk_row_t rows [5] = '{'{8'h07, 8'h41, 8'h04, 2'h0}, '{SUB_UNLOCK, 8'h41, 8'h04, 2'h0},
        '{SUB_LOCK, 8'h40, 8'h00, 2'h1}, '{SUB_SETPW, 8'h41, 8'h04, 2'h1},
        '{SUB_LOCK, 8'h41, 8'h04, 2'h1}};

    hpalk_core #(.CNT_W(3)) i_dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .lockState(lockState), .setMaxAddrReq(setMaxAddrReq));
    hpalk_host i_host (.core_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (setMaxAddrReq === 1'b1) nPulse <= nPulse + 1;
    end

    function automatic logic [15:0] pw(input int k);
        return 16'h1357 + 16'(k) * 16'h0111;
    endfunction : pw

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            nMismatch++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk

    // Poll until ready for a command
    task automatic waitIdle;
        do begin
            i_host.rd(OFF_STATUS, rv, resp);
        end while (rv[ST_BSY] !== 1'b0 || rv[ST_DRDY] !== 1'b1);
    endtask : waitIdle

    task automatic cmd(input logic [7:0] sub, input logic [7:0] code);
        i_host.wr(OFF_SUBCMD, {24'h0, sub}, resp);
        i_host.wr(OFF_CMD, {24'h0, code}, resp);
        waitIdle();
    endtask : cmd

    // One sector, password in words 1 to 16
    task automatic sector(input bit good);
        for (int k = 0; k < 256; k++) begin
            i_host.wr(OFF_DATA, {16'h0, (k >= 1 && k <= 16) ? pw(k - 1) ^ {15'h0, !good}
                : 16'hC3C3}, resp);
        end
        waitIdle();
    endtask : sector

    task automatic unlock(input bit good);
        cmd(SUB_UNLOCK, CMD_SETMAX);
        if (rv[7:0] === 8'h48) sector(good);
    endtask : unlock

    task automatic checkDone(input logic [7:0] st, input logic [7:0] er, input logic [1:0] lk);
        i_host.rd(OFF_STATUS, rv, resp);
        chk("status", {24'h0, st}, rv);
        i_host.rd(OFF_ERROR, rv, resp);
        chk("error", {24'h0, er}, rv);
        chk("lock state", {30'h0, lk}, {30'h0, lockState});
    endtask : checkDone

    task automatic attempts(input logic [7:0] n);
        i_host.rd(OFF_INFO, rv, resp);
        chk("attempts", {24'h0, n}, {24'h0, rv[15:8]});
    endtask : attempts

    task stop_test;
        $display("comparisons %0d, mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    initial begin
        repeat (60000) @(posedge core_clk);
        nMismatch++;
        $display("unexpected watchdog: expected end, seen hang");
        stop_test();
    end

    initial begin
        rstn = 1'b0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        checkDone(8'h40, 8'h00, 2'h0);
        attempts(8'h05);
        $display("test reset done");
        for (int k = 0; k < 16; k++) i_host.wr(OFF_PWBASE + 8'(4 * k), {16'h0, pw(k)}, resp);
        cmd(SUB_SETPW, CMD_SETMAX);
        chk("data request", 32'h48, rv);
        sector(1'b1);
        checkDone(8'h40, 8'h00, 2'h0);
        foreach (rows[i]) begin
            cmd(rows[i].sub, CMD_SETMAX);
            checkDone(rows[i].st, rows[i].er, rows[i].lk);
            $display("test row %0d done", i);
        end
        unlock(1'b0);
        checkDone(8'h41, 8'h04, 2'h1);
        attempts(8'h04);
        unlock(1'b1);
        checkDone(8'h40, 8'h00, 2'h0);
        cmd(SUB_LOCK, CMD_SETMAX);
        attempts(8'h05);
        $display("test unlock done");
        for (int i = 0; i < 5; i++) begin
            unlock(1'b0);
            checkDone(8'h41, 8'h04, 2'h1);
            attempts(8'(4 - i));
        end
        unlock(1'b1);
        checkDone(8'h41, 8'h04, 2'h1);
        attempts(8'h00);
        $display("test attempts done");
        cmd(SUB_UNLOCK, CMD_READNATIVE);
        cmd(SUB_UNLOCK, CMD_SETMAX);
        chk("address request", 32'h1, nPulse);
        chk("lock after request", 32'h1, {30'h0, lockState});
        checkDone(8'h40, 8'h00, 2'h1);
        i_host.wr(OFF_DRVHEAD, 32'h10, resp);
        i_host.rd(OFF_CTRL, rv, resp);
        chk("device select", 32'h1, {31'h0, rv[0]});
        i_host.rd(8'h30, rv, resp);
        chk("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("test misc done");
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        checkDone(8'h40, 8'h00, 2'h0);
        attempts(8'h05);
        $display("test power cycle done");
        cmd(SUB_FREEZE, CMD_SETMAX);
        checkDone(8'h41, 8'h04, 2'h0);
        cmd(SUB_SETPW, CMD_SETMAX);
        sector(1'b1);
        cmd(SUB_LOCK, CMD_SETMAX);
        checkDone(8'h40, 8'h00, 2'h1);
        cmd(SUB_FREEZE, CMD_SETMAX);
        checkDone(8'h40, 8'h00, 2'h2);
        unlock(1'b1);
        checkDone(8'h41, 8'h04, 2'h2);
        $display("test freeze done");
        stop_test();
    end
endmodule : test_hpalk_core
`default_nettype wire
